// *** tb/bbr_mem_model.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Memory partner model
// ****************************************************************

// Read data is driven inverted outside the ack cycle, so a bridge that samples
// it late cannot pass by luck.
module bbr_mem_model
    import bbr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [1:0]   lag,
    input  wire bbr_mem_req_t mem_req,
    output logic              mem_ack,
    output logic [31:0]       mem_rdata
);
    logic [31:0] mem [0:4095];
    logic [31:0] rd_q;
    logic [1:0]  cnt;
    logic [3:0]  lanes;
    logic [11:0] ix;

    assign ix        = {mem_req.addr[30], mem_req.addr[25], mem_req.addr[11:2]};
    assign mem_rdata = mem_ack ? rd_q : ~rd_q;

    always_comb begin
        case (mem_req.size)
            BBR_SZ_BYTE: lanes = 4'h1 << mem_req.addr[1:0];
            BBR_SZ_HALF: lanes = 4'h3 << {mem_req.addr[1], 1'b0};
            default:     lanes = 4'hF;
        endcase
    end

    initial begin
        foreach (mem[i]) mem[i] = 32'h0;
    end

    // An ack answers the request sampled at the edge that raises it, lag+1 cycles after the request first shows.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_ack <= 1'b0;
            cnt     <= 2'h0;
            rd_q    <= 32'h0;
        end else if (mem_ack || !mem_req.valid) begin
            mem_ack <= 1'b0;
            cnt     <= 2'h0;
        end else if (cnt != lag) begin
            cnt <= cnt + 2'h1;
        end else begin
            mem_ack <= 1'b1;
            rd_q    <= mem[ix];
            for (int b = 0; b < 4; b++) begin
                if (mem_req.write && lanes[b])
                    mem[ix][8*b +: 8] <= mem_req.wdata[8*b +: 8];
            end
        end
    end
endmodule

// *** tb/bbr_remap_bench.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Bit-band remapper bench
// ****************************************************************

module bbr_remap_bench;
    import bbr_pkg::*;
    logic         clk;
    logic         rst_b;
    logic [1:0]   lag;
    bbr_cpu_req_t cpu_req;
    bbr_cpu_rsp_t cpu_rsp;
    bbr_mem_req_t mem_req;
    logic         mem_ack;
    logic [31:0]  mem_rdata;
    int           miscompares;
    int           n_checks;

    bbr_remap u_bbr_remap (.clk(clk), .rst_b(rst_b), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
                           .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req));
    bbr_mem_model u_bbr_mem_model (.clk(clk), .rst_b(rst_b), .lag(lag), .mem_req(mem_req),
                                   .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic int ix(input logic [31:0] a);
        return int'({a[30], a[25], a[11:2]});
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Starts in a cycle where the bridge is idle, returns in its done cycle.
    task automatic access(input logic f, input logic w, input logic [1:0] sz,
                          input logic [31:0] a, input logic [31:0] d,
                          input logic [31:0] exp, input logic err);
        int n;
        cpu_req = '{1'b1, f, w, sz, a, d};
        @(posedge clk);
        #2;
        cpu_req.valid = 1'b0;
        if (!err) check({30'h0, mem_req.size}, {30'h0, sz});
        if (!err) check({31'h0, cpu_rsp.busy}, 32'h1);
        for (n = 0; n < 40 && cpu_rsp.done !== 1'b1; n++) begin
            @(posedge clk);
            #2;
        end
        check({31'h0, cpu_rsp.done}, 32'h1);
        check({31'h0, cpu_rsp.busy}, 32'h0);
        check({31'h0, cpu_rsp.err}, {31'h0, err});
        if (!w || a[25]) check(cpu_rsp.rdata, exp);
    endtask

    task automatic t_reset();
        check({31'h0, cpu_rsp.busy | cpu_rsp.done | mem_req.valid}, 32'h0);
        $display("Test reset done");
    endtask

    task automatic t_direct();
        u_bbr_mem_model.mem[ix(32'h2000_0010)] = 32'hA1B2_C3D4;
        u_bbr_mem_model.mem[ix(32'h4000_0020)] = 32'h1111_1111;
        u_bbr_mem_model.mem[ix(32'h2200_0040)] = 32'hCAFE_0001;
        access(0, 0, BBR_SZ_WORD, 32'h2000_0010, 0, 32'hA1B2_C3D4, 0);
        access(0, 1, BBR_SZ_BYTE, 32'h2000_0013, 32'h5A00_0000, 0, 0);
        check(u_bbr_mem_model.mem[ix(32'h2000_0010)], 32'h5AB2_C3D4);
        access(0, 1, BBR_SZ_HALF, 32'h4000_0022, 32'h7788_0000, 0, 0);
        check(u_bbr_mem_model.mem[ix(32'h4000_0020)], 32'h7788_1111);
        access(1, 0, BBR_SZ_WORD, 32'h2200_0040, 0, 32'hCAFE_0001, 0);
        $display("Test direct done");
    endtask

    task automatic t_alias_rd();
        logic [31:0] v;
        v = 32'h0000_A581;
        u_bbr_mem_model.mem[ix(32'h2000_0000)] = v;
        u_bbr_mem_model.mem[ix(32'h200F_FFFC)] = 32'h8000_0000;
        u_bbr_mem_model.mem[ix(32'h4000_0000)] = 32'h0002_0000;
        for (int n = 0; n < 16; n++) begin
            access(0, 0, n < 8 ? BBR_SZ_WORD : BBR_SZ_BYTE, 32'h2200_0000 + (n / 8) * 32 +
                   (n % 8) * 4, 0, {31'h0, v[n]}, 0);
        end
        access(0, 0, BBR_SZ_WORD, 32'h23FF_FFFC, 0, 32'h1, 0);
        access(0, 0, BBR_SZ_WORD, 32'h23FF_FFE0, 0, 32'h0, 0);
        access(0, 0, BBR_SZ_HALF, 32'h4200_0044, 0, 32'h1, 0);
        $display("Test alias read done");
    endtask

    task automatic t_alias_wr();
        lag = 2'h3;
        u_bbr_mem_model.mem[ix(32'h2000_0004)] = 32'h0000_0001;
        access(0, 1, BBR_SZ_WORD, 32'h2200_00AC, 32'hFF, 0, 0);
        access(0, 1, BBR_SZ_WORD, 32'h2200_0080, 32'h0E, 0, 0);
        access(0, 1, BBR_SZ_BYTE, 32'h2200_00FC, 32'h01, 0, 0);
        check(u_bbr_mem_model.mem[ix(32'h2000_0004)], 32'h8000_0800);
        lag = 2'h0;
        u_bbr_mem_model.mem[ix(32'h4000_0000)] = 32'hFFFF_FFFF;
        access(0, 1, BBR_SZ_WORD, 32'h4200_0054, 32'h0E, 0, 0);
        check(u_bbr_mem_model.mem[ix(32'h4000_0000)], 32'hFFDF_FFFF);
        access(0, 0, BBR_SZ_WORD, 32'h4200_0054, 0, 32'h0, 0);
        $display("Test alias write done");
    endtask

    task automatic t_refuse();
        access(1, 0, BBR_SZ_WORD, 32'h4200_0054, 0, 32'h0, 1);
        access(0, 1, BBR_SZ_BAD, 32'h4200_0058, 32'h0, 32'h0, 1);
        check(u_bbr_mem_model.mem[ix(32'h4000_0000)], 32'hFFDF_FFFF);
        $display("Test refuse done");
    endtask

    task automatic finish_test();
        $display("Checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(3000 * 25);
        miscompares++;
        finish_test();
    end

    initial begin
        rst_b       = 1'b0;
        lag         = 2'h0;
        cpu_req     = '0;
        miscompares = 0;
        n_checks    = 0;
        repeat (4) @(posedge clk);
        #2;
        rst_b = 1'b1;
        t_reset();
        t_direct();
        t_alias_rd();
        t_alias_wr();
        t_refuse();
        finish_test();
    end
endmodule

// *** verilog/bbr_pkg.sv ***
package bbr_pkg;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam logic [31:0] BBR_SRAM_BAND  = 32'h2000_0000;
    localparam logic [31:0] BBR_SRAM_ALIAS = 32'h2200_0000;
    localparam logic [31:0] BBR_PERI_BAND  = 32'h4000_0000;
    localparam logic [31:0] BBR_PERI_ALIAS = 32'h4200_0000;

    // An alias region spans 32 MB, so it is matched on bits 31:25.
    localparam int          BBR_ALIAS_LSB  = 25;
    // A bit-band region spans 1 MB, so its base is matched on bits 31:20.
    localparam int          BBR_BAND_LSB   = 20;

    // ****************************************************************
    // Alias word fields
    // ****************************************************************
    localparam int          BBR_BIT_LSB    = 2;
    localparam int          BBR_BIT_MSB    = 4;
    localparam int          BBR_BYTE_LSB   = 5;
    localparam int          BBR_BYTE_MSB   = 24;

    // ****************************************************************
    // Access sizes
    // ****************************************************************
    localparam logic [1:0]  BBR_SZ_BYTE    = 2'h0;
    localparam logic [1:0]  BBR_SZ_HALF    = 2'h1;
    localparam logic [1:0]  BBR_SZ_WORD    = 2'h2;
    localparam logic [1:0]  BBR_SZ_BAD     = 2'h3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        BBR_IDLE   = 2'b00,
        BBR_DIRECT = 2'b01,
        BBR_RD     = 2'b10,
        BBR_WR     = 2'b11
    } bbr_state_t;

    typedef enum logic [1:0] {
        BBR_K_PLAIN = 2'b00,
        BBR_K_SRAM  = 2'b01,
        BBR_K_PERI  = 2'b10
    } bbr_kind_t;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bbr_cpu_req_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic        err;
        logic [31:0] rdata;
    } bbr_cpu_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bbr_mem_req_t;

    typedef struct packed {
        bbr_state_t   st;
        bbr_kind_t    kind;
        logic         write;
        logic         wbit;
        logic [4:0]   bitpos;
        bbr_cpu_rsp_t rsp;
        bbr_mem_req_t mem;
    } bbr_regs_t;

    localparam bbr_regs_t BBR_REGS_RST = '0;

endpackage

// *** verilog/bbr_remap.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Bit-band alias remapper
// ****************************************************************

// Function
// [R1] Each alias word stands for exactly one bit of its bit-band region.
// [R2] Bit-band targets are the lowest megabyte of SRAM and of peripheral space.
// [R3] SRAM alias area accesses are redirected to bits of the SRAM band.
// [R4] Peripheral alias area accesses are redirected to bits of the peripheral band.
// [R5] The underlying access keeps the original byte, halfword or word size.
// [R6] Direct SRAM band addresses behave as ordinary SRAM accesses.
// [R7] SRAM alias data accesses remap with read-modify-write writes; fetches pass unmapped.
// [R8] Direct peripheral band addresses behave as ordinary peripheral accesses.
// [R9] Peripheral alias data accesses remap with read-modify-write; fetches are refused.
// [R10] Alias offset equals byte offset times 32 plus bit number times 4.
// [R11] The bit number picks one of eight positions in the target byte.
// [R12] A write sets the bit when written bit 0 is one, else clears.
// [R13] Written alias bits 31 down to 1 are ignored.
// [R14] An alias read returns zero or one in bit 0 only.
// [R15] Memory is little-endian: lowest address holds the least significant byte.
// [R16] Read and write halves run back to back, keeping neighbouring bits.
module bbr_remap
    import bbr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire bbr_cpu_req_t cpu_req,
    output bbr_cpu_rsp_t      cpu_rsp,
    input  wire logic         mem_ack,
    input  wire logic [31:0]  mem_rdata,
    output bbr_mem_req_t      mem_req
);

    // ****************************************************************
    // Decoding
    // ****************************************************************

    function automatic bbr_kind_t region_kind(input logic [31:0] a);
        bbr_kind_t k;
        k = BBR_K_PLAIN;
        if (a[31:BBR_ALIAS_LSB] == BBR_SRAM_ALIAS[31:BBR_ALIAS_LSB]) begin
            k = BBR_K_SRAM; // R3
        end else if (a[31:BBR_ALIAS_LSB] == BBR_PERI_ALIAS[31:BBR_ALIAS_LSB]) begin
            k = BBR_K_PERI; // R4
        end
        return k;
    endfunction

    // The byte offset is the alias offset divided by 32, placed on the
    // band base; the address is then aligned to the access size so that a
    // word stays a word on the memory side.
    function automatic logic [31:0] band_addr(input logic [31:0] a,
                                              input logic [1:0]  sz,
                                              input logic [31:0] base);
        logic [31:0] b;
        b = {base[31:BBR_BAND_LSB], a[BBR_BYTE_MSB:BBR_BYTE_LSB]}; // R10
        if (sz == BBR_SZ_WORD) begin
            b[1:0] = 2'h0; // R5
        end else if (sz == BBR_SZ_HALF) begin
            b[0] = 1'b0;
        end
        return b;
    endfunction

    // Memory data lanes follow the byte address, lowest byte in bits 7:0,
    // so the bit's place on the 32-bit bus is lane times 8 plus bit number.
    function automatic logic [4:0] lane_bit(input logic [31:0] a);
        return {a[BBR_BYTE_LSB+1:BBR_BYTE_LSB],
                a[BBR_BIT_MSB:BBR_BIT_LSB]}; // R15
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    bbr_regs_t q;
    bbr_regs_t d;
    logic      accept;
    bbr_kind_t in_kind;

    assign accept  = (q.st == BBR_IDLE) && cpu_req.valid;
    assign in_kind = region_kind(cpu_req.addr);

    always_comb begin
        d          = q;
        d.rsp.done = 1'b0;
        d.rsp.err  = 1'b0;
        case (q.st)
            BBR_IDLE: begin
                if (cpu_req.valid) begin
                    d.kind      = in_kind;
                    d.write     = cpu_req.write;
                    d.wbit      = cpu_req.wdata[0]; // R13
                    d.bitpos    = lane_bit(cpu_req.addr); // R11
                    d.mem.write = cpu_req.write;
                    d.mem.size  = cpu_req.size;
                    d.mem.addr  = cpu_req.addr;
                    d.mem.wdata = cpu_req.wdata;
                    if (in_kind == BBR_K_PLAIN) begin
                        // Band and all other addresses go through untouched.
                        d.mem.valid = 1'b1; // R6
                        d.st        = BBR_DIRECT; // R8
                    end else if (cpu_req.fetch && in_kind == BBR_K_SRAM) begin
                        d.kind      = BBR_K_PLAIN;
                        d.mem.valid = 1'b1;
                        d.st        = BBR_DIRECT; // R7
                    end else if (cpu_req.fetch || cpu_req.size == BBR_SZ_BAD) begin
                        d.rsp.done  = 1'b1;
                        d.rsp.err   = 1'b1; // R9
                        d.rsp.rdata = 32'h0000_0000;
                    end else begin
                        // Both reads and writes begin with a read of the target.
                        d.mem.valid = 1'b1;
                        d.mem.write = 1'b0;
                        d.mem.addr  = band_addr(cpu_req.addr, cpu_req.size,
                                                (in_kind == BBR_K_SRAM) ?
                                                BBR_SRAM_BAND : BBR_PERI_BAND); // R2
                        d.st        = BBR_RD; // R1
                    end
                end
            end
            BBR_DIRECT: begin
                if (mem_ack) begin
                    d.mem.valid = 1'b0;
                    d.rsp.done  = 1'b1;
                    d.rsp.rdata = mem_rdata;
                    d.st        = BBR_IDLE;
                end
            end
            BBR_RD: begin
                if (mem_ack) begin
                    if (q.write) begin
                        // The memory port is never released between the two
                        // halves, so no other master can slip in and lose a
                        // neighbouring bit.
                        d.mem.write            = 1'b1; // R16
                        d.mem.wdata            = mem_rdata;
                        d.mem.wdata[q.bitpos]  = q.wbit; // R12
                        d.st                   = BBR_WR;
                    end else begin
                        d.mem.valid = 1'b0;
                        d.rsp.done  = 1'b1;
                        d.rsp.rdata = {31'h0000_0000, mem_rdata[q.bitpos]}; // R14
                        d.st        = BBR_IDLE;
                    end
                end
            end
            BBR_WR: begin
                if (mem_ack) begin
                    d.mem.valid = 1'b0;
                    d.rsp.done  = 1'b1;
                    d.rsp.rdata = 32'h0000_0000;
                    d.st        = BBR_IDLE;
                end
            end
            default: begin
                d = BBR_REGS_RST;
            end
        endcase
        d.rsp.busy = (d.st != BBR_IDLE);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= BBR_REGS_RST;
        end else begin
            q <= d;
        end
    end

    assign cpu_rsp = q.rsp;
    assign mem_req = q.mem;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_take_alias_data;
        accept && !cpu_req.fetch && cpu_req.size != BBR_SZ_BAD &&
            in_kind != BBR_K_PLAIN;
    endsequence

    sequence s_rd_done_wr;
        q.st == BBR_RD && mem_ack && q.write;
    endsequence

    sequence s_wr_issue;
        mem_req.valid && mem_req.write && $stable(mem_req.addr);
    endsequence

    property p_direct_pass;
        accept && in_kind == BBR_K_PLAIN |=>
            q.st == BBR_DIRECT && mem_req.valid &&
            mem_req.addr == $past(cpu_req.addr);
    endproperty
    a_direct_pass: assert property (p_direct_pass) // R6
        else $error("direct access altered");

    property p_sram_fetch;
        accept && cpu_req.fetch && in_kind == BBR_K_SRAM |=>
            q.st == BBR_DIRECT && mem_req.addr == $past(cpu_req.addr);
    endproperty
    a_sram_fetch: assert property (p_sram_fetch) // R7
        else $error("sram alias fetch was remapped");

    // A request may be taken in the done cycle and refused as well, so a
    // second done pulse right after the first is legal only in that case.
    property p_peri_fetch;
        accept && cpu_req.fetch && in_kind == BBR_K_PERI |=>
            cpu_rsp.done && cpu_rsp.err && !mem_req.valid ##1
            (!cpu_rsp.done || $past(accept));
    endproperty
    a_peri_fetch: assert property (p_peri_fetch) // R9
        else $error("peripheral alias fetch not refused");

    property p_sram_target;
        s_take_alias_data and (in_kind == BBR_K_SRAM) |=>
            q.st == BBR_RD && !mem_req.write &&
            mem_req.addr[31:BBR_BAND_LSB] == BBR_SRAM_BAND[31:BBR_BAND_LSB];
    endproperty
    a_sram_target: assert property (p_sram_target) // R3
        else $error("sram alias not sent to sram band");

    property p_peri_target;
        s_take_alias_data and (in_kind == BBR_K_PERI) |=>
            mem_req.addr[31:BBR_BAND_LSB] == BBR_PERI_BAND[31:BBR_BAND_LSB];
    endproperty
    a_peri_target: assert property (p_peri_target) // R4
        else $error("peripheral alias not sent to peripheral band");

    property p_byte_offset;
        s_take_alias_data and (cpu_req.size == BBR_SZ_BYTE) |=>
            mem_req.addr[BBR_BAND_LSB-1:0] ==
                $past(cpu_req.addr[BBR_BYTE_MSB:BBR_BYTE_LSB]);
    endproperty
    a_byte_offset: assert property (p_byte_offset) // R10
        else $error("alias byte offset wrong");

    property p_size_kept;
        accept && !cpu_req.fetch && cpu_req.size != BBR_SZ_BAD |=>
            mem_req.size == $past(cpu_req.size);
    endproperty
    a_size_kept: assert property (p_size_kept) // R5
        else $error("access size changed");

    property p_bit_sel;
        s_take_alias_data |=>
            q.bitpos[2:0] == $past(cpu_req.addr[BBR_BIT_MSB:BBR_BIT_LSB]) &&
            q.wbit == $past(cpu_req.wdata[0]);
    endproperty
    a_bit_sel: assert property (p_bit_sel) // R11
        else $error("bit number or written bit wrong");

    property p_rmw_back;
        s_rd_done_wr |=> s_wr_issue;
    endproperty
    a_rmw_back: assert property (p_rmw_back) // R16
        else $error("write half did not follow read half");

    property p_set_clear;
        s_rd_done_wr |=> mem_req.wdata[q.bitpos] == q.wbit;
    endproperty
    a_set_clear: assert property (p_set_clear) // R12
        else $error("target bit not written");

    property p_one_bit;
        s_rd_done_wr |=>
            ((mem_req.wdata ^ $past(mem_rdata)) & ~(32'h0000_0001 << q.bitpos))
                == 32'h0000_0000;
    endproperty
    a_one_bit: assert property (p_one_bit) // R1
        else $error("neighbouring bits changed");

    property p_read_bit;
        q.st == BBR_RD && mem_ack && !q.write |=>
            cpu_rsp.done && !cpu_rsp.err &&
            cpu_rsp.rdata == (($past(mem_rdata) >> q.bitpos) & 32'h0000_0001);
    endproperty
    a_read_bit: assert property (p_read_bit) // R14
        else $error("alias read value wrong");

    property p_peri_direct;
        accept && in_kind == BBR_K_PLAIN &&
            cpu_req.addr[31:BBR_BAND_LSB] == BBR_PERI_BAND[31:BBR_BAND_LSB] |=>
            mem_req.valid && mem_req.write == $past(cpu_req.write) &&
            mem_req.addr == $past(cpu_req.addr);
    endproperty
    a_peri_direct: assert property (p_peri_direct) // R8
        else $error("direct peripheral access altered");

    // The memory side relies on a request standing still until its ack.
    property p_mem_hold;
        mem_req.valid && !mem_ack |=>
            mem_req.valid && $stable(mem_req.addr) && $stable(mem_req.write) &&
            $stable(mem_req.wdata) && $stable(mem_req.size);
    endproperty
    a_mem_hold: assert property (p_mem_hold) // R16
        else $error("memory request changed before ack");

    property p_err_refused;
        cpu_rsp.err |-> cpu_rsp.done && !mem_req.valid &&
            cpu_rsp.rdata == 32'h0000_0000;
    endproperty
    a_err_refused: assert property (p_err_refused) // R9
        else $error("refused request answered wrongly");

    property p_done_idle;
        cpu_rsp.done |-> !cpu_rsp.busy && q.st == BBR_IDLE;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("busy high in done cycle");

    property p_busy_idle;
        q.st != BBR_IDLE |-> cpu_rsp.busy;
    endproperty
    a_busy_idle: assert property (p_busy_idle)
        else $error("busy low while transfer open");

endmodule
